// ==== rtl/fault_annunciator_defs.vh ====
`ifndef FAULT_ANNUNCIATOR_DEFS_VH
`define FAULT_ANNUNCIATOR_DEFS_VH

// APB register byte addresses.
`define ADDR_STATUS     12'h000
`define ADDR_MASK       12'h004
`define ADDR_CONTROL    12'h008
`define ADDR_ACTIVE     12'h00C
`define ADDR_CODE       12'h010
`define ADDR_TASKCFG    12'h014

// Fault bit positions shared by the status, mask and active registers.
`define F_TASK          0
`define F_WDOG          1
`define F_BUS           2
`define F_OVLD          3
`define F_FATAL         4
`define F_CYCSET        5
`define F_CYCTMO        6
`define F_LINK          7
`define F_NVM           8
`define NFAULT          9

// Control register bits.
`define C_ERRRST        0
`define C_PWRCYC        1

// Display character codes (ASCII).
`define CH_T            8'h74
`define CH_H            8'h48
`define CH_Y            8'h59
`define CH_E            8'h45
`define CH_F            8'h46
`define CH_9            8'h39
`define CH_1            8'h31
`define CH_2            8'h32
`define CH_3            8'h33
`define CH_0            8'h30
`define CH_BLANK        8'h20

// Sizes.
`define NTASK           4
`define NAXIS           16

`endif

// ==== rtl/pin_sync.v ====
`timescale 1ns/1ps

// Three-stage synchroniser; the output changes once stages two and three agree.
module pin_sync #(
   parameter W = 1
) (
   // Clock and reset.
   input  wire         i_clk,
   input  wire         i_srst,
   // Data.
   input  wire [W-1:0] i_async,
   output reg  [W-1:0] o_sync
);
   reg [W-1:0] s1;
   reg [W-1:0] s2;
   reg [W-1:0] s3;

   // Stage one feeds only stage two, keeping metastability out of the compare.
   always @(posedge i_clk) begin
      if (i_srst) begin
         s1     <= {W{1'b0}};
         s2     <= {W{1'b0}};
         s3     <= {W{1'b0}};
         o_sync <= {W{1'b0}};
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
         o_sync <= (s2 & ~(s2 ^ s3)) | (o_sync & (s2 ^ s3));
      end
   end
endmodule // pin_sync

// ==== rtl/fault_annunciator_reaction.v ====
`timescale 1ns/1ps
`include "fault_annunciator_defs.vh"

// Behaviour
// - bad task condition data: tN, RUN, unit lamp, decelerate task
// - watchdog fault: HF, RUN and host lamp
// - bus fault: H9, host lamp, outputs off
// - host overload: HE, RUN and host lamp
// - fatal host fault: HH, host lamp, outputs off
// - bad cycle setting: Y1, only power cycle clears
// - cycle timing timeout: Y2, stop all axes now
// - link exchange fault: Y3, decelerate axis, reset clears
module fault_annunciator_reaction (
   // Clock and reset.
   input  wire        i_clk,
   input  wire        i_srst,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Fault event pins from outside the clock domain.
   input  wire        i_task_cond_bad,
   input  wire [1:0]  i_task_num,
   input  wire        i_host_wdog,
   input  wire        i_bus_fault,
   input  wire        i_host_overload,
   input  wire        i_host_fatal,
   input  wire        i_cycle_set_bad,
   input  wire        i_cycle_timeout,
   input  wire        i_link_fault,
   input  wire [3:0]  i_link_axis,
   input  wire        i_nvm_fault,
   // Power cycle marker, asserted once after power-up.
   input  wire        i_power_cycle,
   // Indicators and display.
   output reg         o_run_lamp,
   output reg         o_unit_fault_lamp,
   output reg         o_host_fault_lamp,
   output reg  [7:0]  o_code_char0,
   output reg  [7:0]  o_code_char1,
   // Protective reactions.
   output reg  [`NTASK-1:0] o_task_decel,
   output reg  [`NAXIS-1:0] o_axis_decel,
   output reg         o_stop_all,
   output reg         o_outputs_off,
   // Interrupt.
   output wire        o_irq
);
   // Synchronised fault pins. Task and axis numbers travel with their strobes.
   wire [9:0] ev_sync;
   wire [5:0] sel_sync;

   pin_sync #(.W(10)) u_sync_ev (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_async ({i_power_cycle, i_nvm_fault, i_link_fault, i_cycle_timeout,
                 i_cycle_set_bad, i_host_fatal, i_host_overload, i_bus_fault,
                 i_host_wdog, i_task_cond_bad}),
      .o_sync  (ev_sync)
   );

   // Selector pins settle before their strobe, so sharing the latency keeps them paired.
   pin_sync #(.W(6)) u_sync_sel (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_async ({i_link_axis, i_task_num}),
      .o_sync  (sel_sync)
   );

   // Rising-edge detect on synchronised levels; a held pin raises one event.
   // Reset leaves ev_prev low, the idle level of every pin, so no false edge follows.
   reg  [9:0] ev_prev;
   wire [9:0] ev_rise = ev_sync & ~ev_prev;
   wire       pwr_clr = ev_rise[`NFAULT]; // The power-cycle marker sits above the faults.

   always @(posedge i_clk) begin
      if (i_srst) begin
         ev_prev <= 10'h000;
      end else begin
         ev_prev <= ev_sync;
      end
   end

   // Register decode is shared by the access check and the write strobes.
   function reg_hit;
      input [11:0] addr;
      input [11:0] reg_addr;
      begin
         reg_hit = (addr == reg_addr);
      end
   endfunction

   // One-hot select for the task and axis reactions; unused upper bits stay low.
   function [`NAXIS-1:0] one_hot;
      input [3:0] index;
      begin
         one_hot = {{(`NAXIS-1){1'b0}}, 1'b1} << index;
      end
   endfunction

   // APB decode. Zero wait states; unmapped addresses answer with pslverr.
   wire apb_acc = psel & penable;
   wire apb_wr  = apb_acc & pwrite;
   wire mapped  = reg_hit(paddr, `ADDR_STATUS) | reg_hit(paddr, `ADDR_MASK) |
                  reg_hit(paddr, `ADDR_CONTROL) | reg_hit(paddr, `ADDR_ACTIVE) |
                  reg_hit(paddr, `ADDR_CODE) | reg_hit(paddr, `ADDR_TASKCFG);
   assign pready  = 1'b1;
   assign pslverr = apb_acc & ~mapped;

   // Write strobes, one per writable register; only the access phase acts.
   wire wr_status  = apb_wr & reg_hit(paddr, `ADDR_STATUS);
   wire wr_mask    = apb_wr & reg_hit(paddr, `ADDR_MASK);
   wire wr_control = apb_wr & reg_hit(paddr, `ADDR_CONTROL);

   // Control bits are single-cycle pulses; nothing of them is stored.
   wire err_reset = wr_control & pwdata[`C_ERRRST];
   wire sw_pwrcyc = wr_control & pwdata[`C_PWRCYC];
   wire any_pwr   = pwr_clr | sw_pwrcyc;

   // Latched faults, sticky status and mask.
   reg [`NFAULT-1:0] active;
   reg [`NFAULT-1:0] status;
   reg [`NFAULT-1:0] mask;
   reg [1:0]         task_id;
   reg [3:0]         axis_id;

   wire [`NFAULT-1:0] ev = ev_rise[`NFAULT-1:0];

   // Faults cleared by an error reset; cycle setting and encoder storage need power.
   wire [`NFAULT-1:0] fault_one  = {{(`NFAULT-1){1'b0}}, 1'b1};
   wire [`NFAULT-1:0] rst_clears = ~((fault_one << `F_CYCSET) | (fault_one << `F_NVM));

   // Task and axis selects decoded once for the reaction outputs.
   wire [`NAXIS-1:0] task_hot = one_hot({2'b00, task_id});
   wire [`NAXIS-1:0] axis_hot = one_hot(axis_id);

   // Latched faults. A new event in the clearing cycle stays set: set wins over clear.
   always @(posedge i_clk) begin
      if (i_srst) begin
         active <= {`NFAULT{1'b0}};
      end else if (any_pwr) begin
         active <= ev;
      end else if (err_reset) begin
         active <= (active & ~rst_clears) | ev;
      end else begin
         active <= active | ev;
      end
   end

   // Sticky status, cleared by writing ones; an event in the same cycle wins.
   always @(posedge i_clk) begin
      if (i_srst) begin
         status <= {`NFAULT{1'b0}};
      end else if (wr_status) begin
         status <= (status & ~pwdata[`NFAULT-1:0]) | ev;
      end else begin
         status <= status | ev;
      end
   end

   // Interrupt mask, of the same layout as the status register.
   always @(posedge i_clk) begin
      if (i_srst) begin
         mask <= {`NFAULT{1'b0}};
      end else if (wr_mask) begin
         mask <= pwdata[`NFAULT-1:0];
      end
   end

   // Task and axis numbers are captured with their own event only.
   always @(posedge i_clk) begin
      if (i_srst) begin
         task_id <= 2'h0;
         axis_id <= 4'h0;
      end else begin
         if (ev[`F_TASK]) begin
            task_id <= sel_sync[1:0];
         end
         if (ev[`F_LINK]) begin
            axis_id <= sel_sync[5:2];
         end
      end
   end

   // Level interrupt, high while any unmasked status bit is set.
   assign o_irq = |(status & mask);

   // Priority pick: output-off first, then stop-all, then host faults,
   // then the axis fault, the encoder storage fault and last the task fault.
   // Lamps follow the shown fault; a hidden lower fault shows once the higher clears.
   reg [7:0] next_c0;
   reg [7:0] next_c1;
   reg       next_run;
   reg       next_unit;
   reg       next_host;

   always @* begin
      next_c0   = `CH_BLANK;
      next_c1   = `CH_BLANK;
      next_run  = 1'b1;
      next_unit = 1'b0;
      next_host = 1'b0;
      if (active[`F_FATAL]) begin
         next_c0   = `CH_H;
         next_c1   = `CH_H;
         next_host = 1'b1;
      end else if (active[`F_BUS]) begin
         next_c0   = `CH_H;
         next_c1   = `CH_9;
         next_host = 1'b1;
      end else if (active[`F_CYCTMO]) begin
         next_c0   = `CH_Y;
         next_c1   = `CH_2;
         next_host = 1'b1;
      end else if (active[`F_CYCSET]) begin
         next_c0   = `CH_Y;
         next_c1   = `CH_1;
         next_host = 1'b1;
      end else if (active[`F_WDOG]) begin
         next_c0   = `CH_H;
         next_c1   = `CH_F;
         next_host = 1'b1;
      end else if (active[`F_OVLD]) begin
         next_c0   = `CH_H;
         next_c1   = `CH_E;
         next_host = 1'b1;
      end else if (active[`F_LINK]) begin
         next_c0   = `CH_Y;
         next_c1   = `CH_3;
         next_host = 1'b1;
      end else if (active[`F_NVM]) begin
         next_c0   = `CH_E;
         next_c1   = `CH_9;
         next_unit = 1'b1;
      end else if (active[`F_TASK]) begin
         // Task digit runs from one to four for task numbers zero to three.
         next_c0   = `CH_T;
         next_c1   = `CH_1 + {6'h00, task_id};
         next_unit = 1'b1;
      end
   end

   // Displayed code and lamps come from flip-flops.
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_code_char0      <= `CH_BLANK;
         o_code_char1      <= `CH_BLANK;
         o_run_lamp        <= 1'b0;
         o_unit_fault_lamp <= 1'b0;
         o_host_fault_lamp <= 1'b0;
      end else begin
         o_code_char0      <= next_c0;
         o_code_char1      <= next_c1;
         o_run_lamp        <= next_run;
         o_unit_fault_lamp <= next_unit;
         o_host_fault_lamp <= next_host;
      end
   end

   // Reactions follow the latched faults, not the display, so a fault that is
   // hidden behind a higher code still acts on its own task or axis.
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_task_decel  <= {`NTASK{1'b0}};
         o_axis_decel  <= {`NAXIS{1'b0}};
         o_stop_all    <= 1'b0;
         o_outputs_off <= 1'b0;
      end else begin
         o_outputs_off <= active[`F_BUS] | active[`F_FATAL];
         o_stop_all    <= active[`F_CYCTMO];
         o_task_decel  <= active[`F_TASK] ? task_hot[`NTASK-1:0] : {`NTASK{1'b0}};
         o_axis_decel  <= active[`F_LINK] ? axis_hot : {`NAXIS{1'b0}};
      end
   end

   // Register read mux. Control is write-only and reads as zero.
   reg [31:0] next_prdata;

   always @* begin
      next_prdata = 32'h00000000;
      case (paddr)
         `ADDR_STATUS:  next_prdata = {23'h000000, status};
         `ADDR_MASK:    next_prdata = {23'h000000, mask};
         `ADDR_ACTIVE:  next_prdata = {23'h000000, active};
         `ADDR_CODE:    next_prdata = {16'h0000, o_code_char0, o_code_char1};
         `ADDR_TASKCFG: next_prdata = {26'h0000000, axis_id, task_id};
         default:       next_prdata = 32'h00000000;
      endcase
   end

   // Read data is taken in the setup cycle, so it stands through the access phase.
   always @(posedge i_clk) begin
      if (i_srst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end
endmodule // fault_annunciator_reaction

// ==== bench/fault_host_model.sv ====
`timescale 1ns/1ps

// Host-side fault source: each requested event becomes a level on its pin.
module fault_host_model (
   // Clock.
   input  wire logic       i_clk,
   // Event requests and pins.
   input  wire logic [8:0] i_req,
   output logic      [8:0] o_pins
);
   // Registered so pins move just after an edge, as host logic would.
   always @(posedge i_clk) begin
      o_pins <= i_req;
   end
endmodule // fault_host_model

// ==== bench/fault_annunciator_sva.sv ====
`timescale 1ns/1ps
`include "fault_annunciator_defs.vh"

module fault_annunciator_sva (
   // Clock, reset and bus.
   input wire        i_clk,
   input wire        i_srst,
   input wire        psel,
   input wire        penable,
   input wire [11:0] paddr,
   input wire        pslverr,
   // Faults and indicators.
   input wire        i_host_fatal,
   input wire        o_run_lamp,
   input wire        o_unit_fault_lamp,
   input wire        o_host_fault_lamp,
   input wire [7:0]  o_code_char0,
   input wire [7:0]  o_code_char1,
   input wire        o_stop_all,
   input wire        o_outputs_off
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // Both characters together, first one on top.
   wire [15:0] code = {o_code_char0, o_code_char1};
   wire        lh   = o_run_lamp && o_host_fault_lamp;

   chk_bad_addr: assert property (psel && penable && paddr > `ADDR_TASKCFG |-> pslverr)
      else $error("unmapped access not refused");
   chk_hf_lamps: assert property (code == {`CH_H, `CH_F} |-> lh && !o_outputs_off)
      else $error("HF lamps wrong");
   chk_h9_off: assert property (code == {`CH_H, `CH_9} |-> lh && o_outputs_off)
      else $error("H9 reaction wrong");
   chk_he_lamps: assert property (code == {`CH_H, `CH_E} |-> lh && !o_stop_all)
      else $error("HE lamps wrong");
   chk_hh_off: assert property (code == {`CH_H, `CH_H} |-> lh && o_outputs_off)
      else $error("HH reaction wrong");
   chk_y2_stop: assert property (code == {`CH_Y, `CH_2} |-> o_stop_all && lh)
      else $error("Y2 stop missing");
   chk_e9_lamps: assert property (code == {`CH_E, `CH_9} |->
      o_run_lamp && o_unit_fault_lamp && !o_host_fault_lamp)
      else $error("E9 lamps wrong");
   chk_fatal_reacts: assert property ($rose(i_host_fatal) |-> ##[4:8] o_outputs_off)
      else $error("fatal fault did not switch outputs off");
   chk_stop_wins: assert property (o_stop_all |-> code == {`CH_H, `CH_H}
      || code == {`CH_H, `CH_9} || code == {`CH_Y, `CH_2})
      else $error("stop shown under lower code");

   cov_hh: cover property (code == {`CH_H, `CH_H});
   cov_y1: cover property (code == {`CH_Y, `CH_1});
   cov_err: cover property (psel && penable && pslverr);
endmodule // fault_annunciator_sva

bind fault_annunciator_reaction fault_annunciator_sva u_chk (.i_clk(i_clk), .i_srst(i_srst),
   .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
   .i_host_fatal(i_host_fatal), .o_run_lamp(o_run_lamp), .o_unit_fault_lamp(o_unit_fault_lamp),
   .o_host_fault_lamp(o_host_fault_lamp), .o_code_char0(o_code_char0),
   .o_code_char1(o_code_char1), .o_stop_all(o_stop_all), .o_outputs_off(o_outputs_off));

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`include "fault_annunciator_defs.vh"

module testbench;
   logic i_clk = 0, i_srst = 1, psel = 0, penable = 0, pwrite = 0, i_power_cycle = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, run, unit, host, stop, off, irq;
   logic [7:0] c0, c1;
   logic [3:0] tdec;
   logic [15:0] adec;
   logic [8:0] req = 0, pins;
   logic [1:0] tnum = 2'h2;
   logic [3:0] axn = 4'h5;
   integer num_errors = 0, num_checks = 0, i;
   // Display, lamps and reactions packed in one word for comparison.
   wire [40:0] st = {c0, c1, run, unit, host, off, stop, tdec, adec};
   wire [40:0] idle = {16'h2020, 5'b10000, 20'h00000};

   always #5 i_clk = ~i_clk;

   fault_host_model i_host (.i_clk(i_clk), .i_req(req), .o_pins(pins));
   fault_annunciator_reaction i_dut (.i_clk(i_clk), .i_srst(i_srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .i_task_cond_bad(pins[0]), .i_task_num(tnum),
      .i_host_wdog(pins[1]), .i_bus_fault(pins[2]), .i_host_overload(pins[3]),
      .i_host_fatal(pins[4]), .i_cycle_set_bad(pins[5]), .i_cycle_timeout(pins[6]),
      .i_link_fault(pins[7]), .i_link_axis(axn), .i_nvm_fault(pins[8]),
      .i_power_cycle(i_power_cycle), .o_run_lamp(run), .o_unit_fault_lamp(unit),
      .o_host_fault_lamp(host), .o_code_char0(c0), .o_code_char1(c1), .o_task_decel(tdec),
      .o_axis_decel(adec), .o_stop_all(stop), .o_outputs_off(off), .o_irq(irq));

   task final_report;
      if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input [63:0] s, input [63:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task cyc(input integer n);
      repeat (n) @(posedge i_clk);
   endtask

   // One APB transfer; read data is kept, it stands until the next setup.
   task apb(input [11:0] a, input w, input [31:0] d);
      integer n;
      @(posedge i_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge i_clk);
      penable <= 1;
      n = 0;
      do begin @(posedge i_clk); n++; end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         num_errors++;
         final_report;
      end
      // Answer taken at the edge where pready is seen; later checks read settled outputs.
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(negedge i_clk);
   endtask

   // Raise the chosen event pins long enough to pass the synchroniser.
   task fire(input [8:0] m);
      @(posedge i_clk) req <= m;
      cyc(3);
      req <= 0;
      cyc(7);
   endtask

   // Expected code and lamps {run, unit, host, off, stop} for each fault.
   function automatic [20:0] ex(input integer f);
      case (f)
         0: ex = {`CH_T, `CH_3, 5'b11000};
         1: ex = {`CH_H, `CH_F, 5'b10100};
         2: ex = {`CH_H, `CH_9, 5'b10110};
         3: ex = {`CH_H, `CH_E, 5'b10100};
         4: ex = {`CH_H, `CH_H, 5'b10110};
         5: ex = {`CH_Y, `CH_1, 5'b10100};
         6: ex = {`CH_Y, `CH_2, 5'b10101};
         7: ex = {`CH_Y, `CH_3, 5'b10100};
         default: ex = {`CH_E, `CH_9, 5'b11000};
      endcase
   endfunction

   // Main sequence: each fault alone, then clears, priority and bus corners.
   initial begin
      cyc(12);
      i_srst <= 0;
      cyc(3);
      chk(st, idle);
      apb(`ADDR_MASK, 1, 32'h1FF);
      for (i = 0; i < 9; i++) begin
         fire(9'h1 << i);
         chk(st, {ex(i), i == 0 ? 20'h40000 : i == 7 ? 20'h00020 : 20'h0});
         chk(irq, 1);
         apb(`ADDR_STATUS, 0, 0); chk(rd, 32'h1 << i);
         apb(`ADDR_STATUS, 1, 32'h1FF); chk(irq, 0);
         chk(st[40:25], ex(i) >> 5);
         apb(`ADDR_CODE, 0, 0);
         chk(rd, ex(i) >> 5);
         apb(`ADDR_CONTROL, 1, 32'h2); cyc(3); chk(st, idle);
      end
      apb(`ADDR_MASK, 1, 0); fire(9'h002); chk(irq, 0);
      apb(`ADDR_MASK, 1, 32'h2); chk(irq, 1);
      fire(9'h0A3); chk(st[40:25], {`CH_Y, `CH_1});
      apb(`ADDR_CONTROL, 1, 32'h1); cyc(3);
      chk(st[40:25], {`CH_Y, `CH_1});
      apb(`ADDR_ACTIVE, 0, 0); chk(rd, 32'h020);
      @(posedge i_clk) i_power_cycle <= 1;
      cyc(8); i_power_cycle <= 0; cyc(2); chk(st, idle);
      fire(9'h080); apb(`ADDR_CONTROL, 1, 32'h1); cyc(3); chk(st, idle);
      // Task one and axis sixteen together: link code wins, both reactions act.
      tnum <= 2'h0;
      axn <= 4'hF;
      fire(9'h081);
      chk(st, {`CH_Y, `CH_3, 5'b10100, 4'h1, 16'h8000});
      apb(`ADDR_TASKCFG, 0, 0);
      chk(rd, 32'h3C);
      apb(`ADDR_CONTROL, 1, 32'h1);
      cyc(3);
      chk(st, idle);
      fire(9'h1FF); chk(st[40:25], {`CH_H, `CH_H});
      apb(12'h020, 0, 0); chk(err, 1);
      apb(`ADDR_CONTROL, 0, 0); chk(rd, 0);
      apb(`ADDR_MASK, 0, 0); chk(rd, 32'h2);
      final_report;
   end
endmodule // testbench
